/* File: core/smb_map.svh */
// constants of the serial master block
// Notes on behaviour
// (R1) SPI after reset; SSP needs format field and pin mode bit.
// (R2) divider sets serial clock; never faster than 25 MHz.
// (R3) software hands the serial pins to this block first.
// (R4) frame size is any length from 4 to 16 bits.
// (R5) every FIFO entry holds exactly frame size bits.
// (R6) mode field picks transmit-receive, transmit only, receive only.
// (R7) transmit-receive: one received frame stored per frame sent.
// (R8) transmit only: sampled input is thrown away.
// (R9) receive only: dummy frame starts, exactly frame count read; a frame count of 0 still reads one frame.
// (R10) receive only: data out undefined, frames stored when complete.
// (R11) SPI select held whole transfer; ends when transmit FIFO empty.
// (R12) software queues frames without pause, waits empty and idle.
// (R13) busy rises some cycles after a write.
// (R14) sixteen active-low selects chosen by the slave select word.
// (R15) data port write pushes transmit, read pops receive.
// (R16) status: transmit empty, not full, receive full, not empty.
// (R17) configuration accepted only while disabled.
// (R18) clock phase and polarity independently selectable in SPI.
// (R19) input sampled at the middle of each bit.
// (R20) queued SPI frames form one transfer without select release.
// (R21) SSP keeps phase and polarity at zero; the engine shifts SSP frames with phase one (cpha_e).
// (R22) level indications above/below thresholds, self clearing.
// (R23) three sticky error flags, each cleared by its own strobe.
// (R24) raw and masked status, mask enabled at reset, gated irq.
// (R25) FIFO depth is a parameter, fill levels visible.
// (R26) SSP sends a one-clock frame pulse before each frame.
`ifndef SMB_MAP_SVH
`define SMB_MAP_SVH
`define SMB_MODE_TXRX 2'h0
`define SMB_MODE_TX 2'h1
`define SMB_MODE_RX 2'h2
`define SMB_FS_MIN 4'h3
`define SMB_IRQ_TXE 0
`define SMB_IRQ_TXO 1
`define SMB_IRQ_RXU 2
`define SMB_IRQ_RXO 3
`define SMB_IRQ_RXF 4
`define SMB_MASK_RST 5'h1f
`define SMB_SCLK_MAX_MHZ 25
`define SMB_LINK_PERIOD_NS 6
`define SMB_DIV_PROD (`SMB_SCLK_MAX_MHZ * `SMB_LINK_PERIOD_NS)
`define SMB_MIN_DIV 16'((1000 + `SMB_DIV_PROD - 1) / `SMB_DIV_PROD)
`endif

/* File: core/smb_pkg.sv */
// types of the serial master block
package smb_pkg;
  typedef struct packed {
    logic        ssp;
    logic [3:0]  fsize;
    logic [1:0]  mode;
    logic        cpol;
    logic        cpha;
    logic [15:0] div;
    logic [15:0] sel;
    logic [15:0] nframes;
  } smb_cfg_s;
  typedef struct packed {
    logic busy;
    logic tx_fifo_empty;
    logic tx_fifo_not_full;
    logic rx_fifo_full;
    logic rx_fifo_not_empty;
  } smb_status_s;
  typedef enum logic [1:0] {
    SMB_IDLE, SMB_PULSE, SMB_SHIFT, SMB_NEXT
  } smb_state_e;
endpackage

/* File: core/smb_serial_master.sv */
// serial master block: FIFOs, flags and serial engine
`timescale 1ns/1ps
`default_nettype none
`include "smb_map.svh"
module smb_serial_master
  import smb_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int LW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          link_clk_in,
  input  wire logic          enable_in,
  input  wire logic          frame_format_in,
  input  wire logic          ssp_pin_mode_enable_in,
  input  wire logic [3:0]    frame_size_field_in,
  input  wire logic [1:0]    transfer_mode_field_in,
  input  wire logic          clock_polarity_in,
  input  wire logic          clock_phase_in,
  input  wire logic [15:0]   clock_divider_in,
  input  wire logic [15:0]   slave_select_in,
  input  wire logic [15:0]   frame_count_in,
  input  wire logic [LW-1:0] tx_threshold_in,
  input  wire logic [LW-1:0] rx_threshold_in,
  input  wire logic [4:0]    interrupt_mask_in,
  input  wire logic          interrupt_mask_write_in,
  input  wire logic          tx_write_in,
  input  wire logic [15:0]   tx_data_in,
  input  wire logic          rx_read_in,
  input  wire logic          tx_overflow_clear_in,
  input  wire logic          rx_overflow_clear_in,
  input  wire logic          rx_underflow_clear_in,
  input  wire logic          serial_data_in,
  output logic [15:0]        rx_data_out,
  output var smb_status_s    status_word_out,
  output logic [LW-1:0]      tx_fill_level_out,
  output logic [LW-1:0]      rx_fill_level_out,
  output logic [4:0]         raw_interrupt_status_out,
  output logic [4:0]         masked_interrupt_status_out,
  output logic               irq_out,
  output logic               sclk_out,
  output logic               serial_data_out,
  output logic               chip_select_zero_n_out,
  output logic [15:1]        chip_select_n_out,
  output logic               ssp_frame_out
);
  localparam int PW = $clog2(DEPTH);

  // keeps the low frame-size bits of a word
  function automatic logic [15:0] fs_mask(input logic [3:0] fs);
    fs_mask = 16'hffff >> (4'hf - fs);
  endfunction

  // wrapping FIFO pointer step
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // ---------------------------------------------------------------
  // configuration, system clock side
  // ---------------------------------------------------------------
  smb_cfg_s    cfg_r;
  logic        enable_r;
  logic        busy_s1;
  logic        busy_s2;
  logic        tx_ack_s1;
  logic        tx_ack_s2;
  logic        rx_req_s1;
  logic        rx_req_s2;
  logic [15:0] rx_word_l;
  logic        tx_ack_l;
  logic        rx_req_l;
  logic        busy_l_r;

  // settings only load while the block is disabled
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cfg_r    <= '0;
      enable_r <= 1'b0;
    end else begin
      enable_r <= enable_in;
      if (!enable_in) begin // R17
        cfg_r.ssp   <= frame_format_in & ssp_pin_mode_enable_in; // R1
        cfg_r.fsize <= (frame_size_field_in < `SMB_FS_MIN) ?
                       `SMB_FS_MIN : frame_size_field_in; // R4
        cfg_r.mode  <= transfer_mode_field_in; // R6
        cfg_r.cpol  <= clock_polarity_in &
                       ~(frame_format_in & ssp_pin_mode_enable_in); // R18 R21
        cfg_r.cpha  <= clock_phase_in &
                       ~(frame_format_in & ssp_pin_mode_enable_in); // R18 R21
        cfg_r.div   <= (clock_divider_in < `SMB_MIN_DIV) ?
                       `SMB_MIN_DIV : clock_divider_in; // R2
        cfg_r.sel   <= slave_select_in; // R14
        cfg_r.nframes <= frame_count_in; // R9
      end
    end
  end

  // synchronisers from the link domain
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      busy_s1   <= 1'b0;
      busy_s2   <= 1'b0;
      tx_ack_s1 <= 1'b0;
      tx_ack_s2 <= 1'b0;
      rx_req_s1 <= 1'b0;
      rx_req_s2 <= 1'b0;
    end else begin
      busy_s1   <= busy_l_r;
      busy_s2   <= busy_s1; // R13
      tx_ack_s1 <= tx_ack_l;
      tx_ack_s2 <= tx_ack_s1;
      rx_req_s1 <= rx_req_l;
      rx_req_s2 <= rx_req_s1;
    end
  end

  // ---------------------------------------------------------------
  // transmit FIFO and hand-over word
  // ---------------------------------------------------------------
  logic [15:0]   tx_mem [DEPTH];
  logic [PW-1:0] tx_wp_r;
  logic [PW-1:0] tx_rp_r;
  logic [LW-1:0] tx_cnt_r;
  logic [15:0]   hold_r;
  logic          tx_req_r;
  logic          tx_full;
  logic          hold_full;
  logic          tx_push;
  logic          tx_pop;
  logic          tx_ovf;

  assign tx_full   = tx_cnt_r == LW'(DEPTH);
  assign hold_full = tx_req_r ^ tx_ack_s2;
  assign tx_push   = tx_write_in & enable_r & ~tx_full; // R15
  assign tx_ovf    = tx_write_in & tx_full;
  assign tx_pop    = ~hold_full & (tx_cnt_r != '0) & enable_r;

  // storage is trimmed to the frame size on entry
  always_ff @(posedge clk_in) begin
    if (tx_push) begin
      tx_mem[tx_wp_r] <= tx_data_in & fs_mask(cfg_r.fsize); // R5
    end
  end

  // transmit pointers and fill level
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_wp_r  <= '0;
      tx_rp_r  <= '0;
      tx_cnt_r <= '0;
    end else begin
      if (tx_push) begin
        tx_wp_r <= ptr_inc(tx_wp_r);
      end
      if (tx_pop) begin
        tx_rp_r <= ptr_inc(tx_rp_r);
      end
      tx_cnt_r <= tx_cnt_r + LW'(tx_push) - LW'(tx_pop); // R25
    end
  end

  // one word waits here for the link; the toggle marks it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hold_r   <= '0;
      tx_req_r <= 1'b0;
    end else if (tx_pop) begin
      hold_r   <= tx_mem[tx_rp_r];
      tx_req_r <= ~tx_req_r;
    end
  end

  // ---------------------------------------------------------------
  // receive FIFO
  // ---------------------------------------------------------------
  logic [15:0]   rx_mem [DEPTH];
  logic [PW-1:0] rx_wp_r;
  logic [PW-1:0] rx_rp_r;
  logic [LW-1:0] rx_cnt_r;
  logic          rx_seen_r;
  logic          rx_new;
  logic          rx_full;
  logic          rx_push;
  logic          rx_ovf;
  logic          rx_pop;
  logic          rx_unf;

  assign rx_new  = rx_req_s2 ^ rx_seen_r;
  assign rx_full = rx_cnt_r == LW'(DEPTH);
  assign rx_push = rx_new & ~rx_full;
  assign rx_ovf  = rx_new & rx_full;
  assign rx_pop  = rx_read_in & (rx_cnt_r != '0); // R15
  assign rx_unf  = rx_read_in & (rx_cnt_r == '0);

  // received word is stable while its toggle is in flight
  always_ff @(posedge clk_in) begin
    if (rx_push) begin
      rx_mem[rx_wp_r] <= rx_word_l & fs_mask(cfg_r.fsize); // R5
    end
  end

  // receive pointers, fill level and read data
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_wp_r     <= '0;
      rx_rp_r     <= '0;
      rx_cnt_r    <= '0;
      rx_seen_r   <= 1'b0;
      rx_data_out <= '0;
    end else begin
      rx_seen_r <= rx_req_s2;
      if (rx_push) begin
        rx_wp_r <= ptr_inc(rx_wp_r); // R10
      end
      if (rx_pop) begin
        rx_rp_r     <= ptr_inc(rx_rp_r);
        rx_data_out <= rx_mem[rx_rp_r];
      end
      rx_cnt_r <= rx_cnt_r + LW'(rx_push) - LW'(rx_pop); // R25
    end
  end

  // ---------------------------------------------------------------
  // flags and status outputs
  // ---------------------------------------------------------------
  logic       txo_r;
  logic       rxo_r;
  logic       rxu_r;
  logic [4:0] mask_r;
  logic [4:0] raw_c;

  // sticky errors; a new event beats a clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      txo_r  <= 1'b0;
      rxo_r  <= 1'b0;
      rxu_r  <= 1'b0;
      mask_r <= `SMB_MASK_RST; // R24
    end else begin
      txo_r <= tx_ovf | (txo_r & ~tx_overflow_clear_in); // R23
      rxo_r <= rx_ovf | (rxo_r & ~rx_overflow_clear_in); // R23
      rxu_r <= rx_unf | (rxu_r & ~rx_underflow_clear_in); // R23
      if (interrupt_mask_write_in) begin
        mask_r <= interrupt_mask_in;
      end
    end
  end

  // raw sources; level ones clear by themselves
  always_comb begin
    raw_c = '0;
    raw_c[`SMB_IRQ_TXE] = tx_cnt_r < tx_threshold_in; // R22
    raw_c[`SMB_IRQ_RXF] = rx_cnt_r > rx_threshold_in; // R22
    raw_c[`SMB_IRQ_TXO] = txo_r;
    raw_c[`SMB_IRQ_RXU] = rxu_r;
    raw_c[`SMB_IRQ_RXO] = rxo_r;
  end

  // registered status, levels and interrupt
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      status_word_out   <= '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      tx_fill_level_out <= '0;
      rx_fill_level_out <= '0;
      raw_interrupt_status_out    <= '0;
      masked_interrupt_status_out <= '0;
      irq_out <= 1'b0;
    end else begin
      status_word_out.busy <= busy_s2;
      status_word_out.tx_fifo_empty  <= (tx_cnt_r == '0) & ~hold_full; // R16
      status_word_out.tx_fifo_not_full <= ~tx_full; // R16
      status_word_out.rx_fifo_full  <= rx_full; // R16
      status_word_out.rx_fifo_not_empty <= rx_cnt_r != '0; // R16
      tx_fill_level_out <= tx_cnt_r;
      rx_fill_level_out <= rx_cnt_r;
      raw_interrupt_status_out    <= raw_c; // R24
      masked_interrupt_status_out <= raw_c & mask_r; // R24
      irq_out <= (|(raw_c & mask_r)) & enable_r; // R24
    end
  end

  // ---------------------------------------------------------------
  // link domain: crossings
  // ---------------------------------------------------------------
  logic        lrst_s1;
  logic        lrst_s2;
  logic        en_s1;
  logic        en_s2;
  logic        treq_s1;
  logic        treq_s2;
  logic        rack_s1;
  logic        rack_s2;
  logic        sdi_s1;
  logic        sdi_s2;
  smb_cfg_s    cfg_l;

  // reset release into the link domain
  always_ff @(posedge link_clk_in) begin
    lrst_s1 <= rst_n_in;
    lrst_s2 <= lrst_s1;
  end

  // level synchronisers; settings copied while disabled
  always_ff @(posedge link_clk_in) begin
    if (!lrst_s2) begin
      en_s1   <= 1'b0;
      en_s2   <= 1'b0;
      treq_s1 <= 1'b0;
      treq_s2 <= 1'b0;
      rack_s1 <= 1'b0;
      rack_s2 <= 1'b0;
      sdi_s1  <= 1'b0;
      sdi_s2  <= 1'b0;
      cfg_l   <= '0;
    end else begin
      en_s1   <= enable_r;
      en_s2   <= en_s1;
      treq_s1 <= tx_req_r;
      treq_s2 <= treq_s1;
      rack_s1 <= rx_seen_r;
      rack_s2 <= rack_s1;
      sdi_s1  <= serial_data_in;
      sdi_s2  <= sdi_s1;
      if (!en_s2) begin
        cfg_l <= cfg_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // link domain: serial engine
  // ---------------------------------------------------------------
  smb_state_e  state_r;
  logic [15:0] hcnt_r;
  logic        half_r;
  logic [3:0]  bit_r;
  logic [15:0] frames_r;
  logic [15:0] txw_r;
  logic [15:0] rxw_r;
  logic [15:0] half_len;
  logic        tick;
  logic        cpha_e;
  logic        take_c;
  logic        start_c;
  logic        finish_c;
  logic        push_c;
  logic        cs_on;
  logic [15:0] first_w;

  assign half_len = 16'((17'(cfg_l.div) + 17'h0_0001) >> 1); // R2
  assign tick     = hcnt_r == half_len - 16'h0001;
  assign cpha_e   = cfg_l.cpha | cfg_l.ssp; // R21
  assign first_w  = take_c ? hold_r : txw_r;

  // frame sequencing decisions
  always_comb begin
    take_c   = 1'b0;
    start_c  = 1'b0;
    finish_c = 1'b0;
    push_c   = 1'b0;
    if (en_s2) begin
      case (state_r)
        SMB_IDLE: begin
          take_c  = treq_s2 ^ tx_ack_l; // R9
          start_c = treq_s2 ^ tx_ack_l;
        end
        SMB_NEXT: begin
          if (!(rx_req_l ^ rack_s2)) begin
            push_c = cfg_l.mode != `SMB_MODE_TX; // R7 R8
            if (cfg_l.mode == `SMB_MODE_RX) begin
              finish_c = frames_r <= 16'h0001; // R9
              start_c  = frames_r > 16'h0001;
            end else begin
              take_c   = treq_s2 ^ tx_ack_l; // R20
              start_c  = treq_s2 ^ tx_ack_l;
              finish_c = ~(treq_s2 ^ tx_ack_l); // R11
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign cs_on = en_s2 & (start_c | (state_r != SMB_IDLE & ~finish_c));

  // selects and busy follow the transfer
  always_ff @(posedge link_clk_in) begin
    if (!lrst_s2) begin
      chip_select_zero_n_out <= 1'b1;
      chip_select_n_out      <= '1;
      busy_l_r               <= 1'b0;
    end else begin
      chip_select_zero_n_out <= ~(cs_on & cfg_l.sel[0]); // R14
      chip_select_n_out      <= ~({15{cs_on}} & cfg_l.sel[15:1]);
      busy_l_r               <= cs_on;
    end
  end

  // bit timing, shifting and hand-over toggles
  always_ff @(posedge link_clk_in) begin
    if (!lrst_s2) begin
      state_r   <= SMB_IDLE;
      hcnt_r    <= '0;
      half_r    <= 1'b0;
      bit_r     <= '0;
      frames_r  <= '0;
      txw_r     <= '0;
      rxw_r     <= '0;
      rx_word_l <= '0;
      tx_ack_l  <= 1'b0;
      rx_req_l  <= 1'b0;
      sclk_out  <= 1'b0;
      serial_data_out <= 1'b0;
      ssp_frame_out   <= 1'b0;
    end else if (!en_s2) begin
      state_r       <= SMB_IDLE;
      sclk_out      <= cfg_l.cpol; // R18
      ssp_frame_out <= 1'b0;
    end else begin
      if (take_c) begin
        txw_r    <= hold_r;
        tx_ack_l <= ~tx_ack_l;
      end
      if (push_c) begin
        rx_word_l <= rxw_r; // R10
        rx_req_l  <= ~rx_req_l;
      end
      if (state_r == SMB_IDLE) begin
        frames_r <= cfg_l.nframes;
        sclk_out <= cfg_l.cpol;
      end else if (state_r == SMB_NEXT && start_c) begin
        frames_r <= frames_r - 16'h0001;
      end
      if (start_c) begin
        state_r       <= cfg_l.ssp ? SMB_PULSE : SMB_SHIFT;
        ssp_frame_out <= cfg_l.ssp; // R26
        hcnt_r        <= '0;
        half_r        <= 1'b0;
        bit_r         <= cfg_l.fsize; // R4
        rxw_r         <= '0;
        if (!cpha_e) begin
          serial_data_out <= first_w[cfg_l.fsize];
        end
      end else if (finish_c) begin
        state_r <= SMB_IDLE; // R11
      end else if (state_r == SMB_PULSE || state_r == SMB_SHIFT) begin
        if (!tick) begin
          hcnt_r <= hcnt_r + 16'h0001;
        end else begin
          hcnt_r   <= '0;
          half_r   <= ~half_r;
          sclk_out <= ~sclk_out; // R18
          if (state_r == SMB_PULSE) begin
            if (half_r) begin
              state_r       <= SMB_SHIFT;
              ssp_frame_out <= 1'b0;
            end
          end else if (!half_r) begin
            // leading edge: drive for phase one, else sample
            if (cpha_e) begin
              serial_data_out <= txw_r[bit_r];
            end else begin
              rxw_r[bit_r] <= sdi_s2; // R19
            end
          end else begin
            // trailing edge: sample for phase one, else drive
            if (cpha_e) begin
              rxw_r[bit_r] <= sdi_s2; // R19
            end else if (bit_r != '0) begin
              serial_data_out <= txw_r[bit_r - 4'h1];
            end
            if (bit_r == '0) begin
              state_r <= SMB_NEXT;
            end else begin
              bit_r <= bit_r - 4'h1;
            end
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_cfg_lock;
    @(posedge clk_in) disable iff (!rst_n_in)
    enable_r && $past(enable_r) |-> $stable(cfg_r);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) // R17
    else $error("settings changed while enabled");

  property p_txo_set;
    @(posedge clk_in) disable iff (!rst_n_in)
    tx_write_in && tx_full |=> ##1 raw_interrupt_status_out[1];
  endproperty
  a_txo_set: assert property (p_txo_set) // R23
    else $error("write overflow not flagged");

  property p_rxu_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
    rxu_r && !rx_underflow_clear_in |=> rxu_r;
  endproperty
  a_rxu_hold: assert property (p_rxu_hold) // R23
    else $error("underflow flag dropped without clear");

  property p_rxf_level;
    @(posedge clk_in) disable iff (!rst_n_in)
    raw_interrupt_status_out[4] ==
      (rx_fill_level_out > $past(rx_threshold_in));
  endproperty
  a_rxf_level: assert property (p_rxf_level) // R22
    else $error("receive level flag wrong");

  property p_irq_gate;
    @(posedge clk_in) disable iff (!rst_n_in)
    irq_out |-> (|masked_interrupt_status_out) && $past(enable_r);
  endproperty
  a_irq_gate: assert property (p_irq_gate) // R24
    else $error("interrupt without enabled source");

  property p_tfe;
    @(posedge clk_in) disable iff (!rst_n_in)
    status_word_out.tx_fifo_empty |-> tx_fill_level_out == '0;
  endproperty
  a_tfe: assert property (p_tfe) // R16
    else $error("transmit empty with entries");

  property p_cs_held;
    @(posedge link_clk_in) disable iff (!lrst_s2)
    $past(state_r) == SMB_SHIFT && state_r != SMB_IDLE
      |-> chip_select_zero_n_out == ~cfg_l.sel[0];
  endproperty
  a_cs_held: assert property (p_cs_held) // R11
    else $error("select released inside transfer");

  property p_tx_nopush;
    @(posedge link_clk_in) disable iff (!lrst_s2)
    state_r == SMB_NEXT && cfg_l.mode == `SMB_MODE_TX |=> $stable(rx_req_l);
  endproperty
  a_tx_nopush: assert property (p_tx_nopush) // R8
    else $error("transmit only stored a frame");

  property p_rx_frames;
    @(posedge link_clk_in) disable iff (!lrst_s2)
    state_r == SMB_SHIFT && cfg_l.mode == `SMB_MODE_RX
      |-> frames_r != '0 || cfg_l.nframes == '0;
  endproperty
  a_rx_frames: assert property (p_rx_frames) // R9
    else $error("receive only ran past frame count");

  property p_ssp_pulse;
    @(posedge link_clk_in) disable iff (!lrst_s2)
    $rose(ssp_frame_out) |-> cfg_l.ssp ##1 ssp_frame_out;
  endproperty
  a_ssp_pulse: assert property (p_ssp_pulse) // R26
    else $error("frame pulse outside SSP");

  c_tx_end: cover property (@(posedge link_clk_in) disable iff (!lrst_s2)
    state_r == SMB_NEXT && finish_c);
  c_rx_only: cover property (@(posedge link_clk_in) disable iff (!lrst_s2)
    push_c && cfg_l.mode == `SMB_MODE_RX);
  c_ssp: cover property (@(posedge link_clk_in) disable iff (!lrst_s2)
    $fell(ssp_frame_out));
  c_rx_ovf: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    rx_ovf);
endmodule
`default_nettype wire

/* File: testbench/smb_slave_model.sv */
// serial slave model answering the block's select and clock
`timescale 1ns/1ps
`default_nettype none
module smb_slave_model (
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic        mosi_in,
  input  wire logic        cpol_in,
  input  wire logic        cpha_in,
  input  wire logic [3:0]  top_in,
  input  wire logic [15:0] word_in,
  output logic             miso_out,
  output logic [15:0]      got_out
);
  int idx = 0;
  initial miso_out = 1'b1;
  initial got_out = 16'h0000;
  // first bit ready at select fall in phase zero
  always @(negedge cs_n_in) begin
    idx = top_in;
    if (!cpha_in) miso_out = word_in[idx];
  end
  // released line shows the inverse of its last bit
  always @(posedge cs_n_in) miso_out = ~miso_out;
  // change edge drives next bit, sample edge shifts mosi in
  always @(sclk_in) begin
    if (!cs_n_in) begin
      if ((sclk_in != cpol_in) == cpha_in) begin
        if (!cpha_in) idx = (idx == 0) ? int'(top_in) : idx - 1;
        miso_out = word_in[idx];
      end else begin
        got_out = {got_out[14:0], mosi_in};
        if (cpha_in) idx = (idx == 0) ? int'(top_in) : idx - 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// bench: scenarios for the serial master block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import smb_pkg::*;
  logic clk_in = 0, lclk = 0, rst_n_in = 0, en = 0, pl = 0, ph = 0;
  logic [1:0] md = 0;
  logic [15:0] nf = 1, wd = 0, sw = 0, rxd, got;
  logic [3:0] rxt = 4'h2, txt = 4'h1, rxfl, txfl;
  logic [4:0] msk = 5'h1f, raw, msd;
  logic mw = 0, wr = 0, rd = 0, sp = 0, miso, sclk, mosi, cs0, frm, irq;
  logic [2:0] clr = 0;
  logic [15:1] csn;
  smb_status_s st;
  int n_mismatch = 0, n_tests = 0, rises = 0, cyc = 0, pulses = 0;
  // ---------------------------------------------------------------
  // clocks, design and slave
  // ---------------------------------------------------------------
  initial forever #10 clk_in = ~clk_in;
  initial #1 forever #3 lclk = ~lclk;
  smb_serial_master smb_serial_master_i (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .link_clk_in(lclk), .enable_in(en),
    .frame_format_in(sp), .ssp_pin_mode_enable_in(sp),
    .frame_size_field_in(4'h7), .transfer_mode_field_in(md),
    .clock_polarity_in(pl), .clock_phase_in(ph),
    .clock_divider_in(16'h0008), .slave_select_in(16'h0002),
    .frame_count_in(nf), .tx_threshold_in(txt), .rx_threshold_in(rxt),
    .interrupt_mask_in(msk), .interrupt_mask_write_in(mw),
    .tx_write_in(wr), .tx_data_in(wd), .rx_read_in(rd),
    .tx_overflow_clear_in(clr[0]), .rx_overflow_clear_in(clr[1]),
    .rx_underflow_clear_in(clr[2]), .serial_data_in(miso),
    .rx_data_out(rxd), .status_word_out(st), .tx_fill_level_out(txfl),
    .rx_fill_level_out(rxfl), .raw_interrupt_status_out(raw),
    .masked_interrupt_status_out(msd), .irq_out(irq),
    .sclk_out(sclk), .serial_data_out(mosi),
    .chip_select_zero_n_out(cs0), .chip_select_n_out(csn),
    .ssp_frame_out(frm));
  smb_slave_model smb_slave_model_i (.sclk_in(sclk), .cs_n_in(csn[1]),
    .mosi_in(mosi), .cpol_in(pl), .cpha_in(ph), .top_in(4'h7),
    .word_in(sw), .miso_out(miso), .got_out(got));
  // select releases, frame pulses and hang guard
  always @(posedge csn[1]) rises++;
  always @(posedge frm) pulses++;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cfg(input logic [1:0] m, input logic p, input logic h);
    @(negedge clk_in) en = 0;
    @(negedge clk_in) begin md = m; pl = p; ph = h; end
    @(negedge clk_in) en = 1;
    rises = 0;
  endtask
  task automatic push(input logic [15:0] d, input int n);
    repeat (n) begin
      @(negedge clk_in);
      wr = 1;
      wd = d;
    end
    @(negedge clk_in) wr = 0;
  endtask
  task automatic pop(input logic [15:0] exp);
    @(negedge clk_in) rd = 1;
    @(negedge clk_in) rd = 0;
    chk(rxd, exp);
  endtask
  task automatic pulse(input logic [3:0] v);
    @(negedge clk_in) {mw, clr} = v;
    @(negedge clk_in) {mw, clr} = 4'h0;
  endtask
  task automatic idle();
    repeat (20) @(negedge clk_in);
    while (!(st.tx_fifo_empty === 1'b1 && st.busy === 1'b0)) @(negedge clk_in);
    repeat (4) @(negedge clk_in);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic s_modes();
    for (int i = 0; i < 4; i++) begin
      sw = 16'h00a5 ^ 16'(i);
      cfg(2'h0, i[1], i[0]);
      push(16'h3c5a, 2);
      idle();
      chk(16'(rxfl), 16'h0002);
      chk(16'(rises), 16'h0001);
      chk(16'(cs0), 16'h0001);
      chk(got[7:0], 16'h005a);
      pop(sw & 16'h00ff);
      pop(sw & 16'h00ff);
    end
  endtask
  task automatic s_ssp();
    sp = 1;
    cfg(2'h1, 1'b0, 1'b0);
    push(16'h0042, 2);
    idle();
    chk(16'(pulses), 16'h0002);
    chk(16'(rises), 16'h0001);
    chk(16'(sclk), 16'h0000);
    sp = 0;
  endtask
  task automatic s_tx_rx_only();
    cfg(2'h1, 1'b0, 1'b0);
    push(16'hff11, 1);
    idle();
    chk(16'(rxfl), 16'h0000);
    chk(got[7:0], 16'h0011);
    nf = 16'h0003;
    sw = 16'h00c3;
    cfg(2'h2, 1'b0, 1'b0);
    push(16'h0000, 1);
    idle();
    chk(16'(rxfl), 16'h0003);
    chk(16'(raw), 16'h0011);
    chk(16'(irq), 16'h0001);
    msk = 5'h00;
    pulse(4'h8);
    @(negedge clk_in);
    chk({8'(msd), 8'(irq)}, 16'h0000);
    msk = 5'h1f;
    pulse(4'h8);
    repeat (3) pop(16'h00c3);
  endtask
  task automatic s_errors();
    pop(16'h00c3);
    repeat (2) @(negedge clk_in);
    chk(16'(raw[2]), 16'h0001);
    cfg(2'h1, 1'b0, 1'b0);
    push(16'h0077, 12);
    repeat (2) @(negedge clk_in);
    chk(16'(raw[1]), 16'h0001);
    chk(16'(st.tx_fifo_not_full), 16'h0000);
    chk(16'(txfl), 16'h0008);
    idle();
    pulse(4'h4);
    pulse(4'h1);
    repeat (2) @(negedge clk_in);
    chk(16'(raw[2:1]), 16'h0000);
    chk(16'(rises), 16'h0001);
  endtask
  initial begin
    repeat (10) @(negedge clk_in);
    chk(16'(st), 16'h000c);
    chk({csn, cs0}, 16'hffff);
    rst_n_in = 1;
    repeat (4) @(posedge lclk);
    s_modes();
    s_ssp();
    s_tx_rx_only();
    s_errors();
    end_of_test();
  end
endmodule
`default_nettype wire
